// File: inc/work_area_consts.svh
`ifndef WORK_AREA_CONSTS_SVH
`define WORK_AREA_CONSTS_SVH

// Register byte offsets
`define WA_OFF_STATUS      12'h000
`define WA_OFF_IRQ_STATUS  12'h004
`define WA_OFF_IRQ_MASK    12'h008
`define WA_OFF_ONE_LOW     12'h010
`define WA_OFF_ONE_HIGH    12'h014
`define WA_OFF_TWO_LOW     12'h018
`define WA_OFF_TWO_HIGH    12'h01c

// Reset values
`define WA_RST_ADDR_LOW    16'h0000
`define WA_RST_ADDR_HIGH   8'h00
`define WA_RST_IRQ         2'h0

// Interrupt status / mask field positions
`define WA_IRQ_PU_BIT      0
`define WA_IRQ_EMPTY_BIT   1

// Status register field positions
`define WA_ST_EMPTY_BIT    0
`define WA_ST_PU_LSB       8

// High register implemented width
`define WA_HIGH_BITS       8

`endif

// File: inc/work_area_pkg.sv
package work_area_pkg;

  typedef logic [15:0] addr_low_t;
  typedef logic [7:0]  addr_high_t;
  typedef logic [23:0] work_addr_t;

endpackage : work_area_pkg

// File: rtl/work_area_irq.sv
`timescale 1ns/1ns
`include "work_area_consts.svh"

module work_area_irq
  import work_area_pkg::*;
#(
  parameter int NUM_EVENTS = 2
)
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Events and software access
  input  wire logic [NUM_EVENTS-1:0] event_set,
  input  wire logic                  clear_write,
  input  wire logic [NUM_EVENTS-1:0] clear_data,
  input  wire logic                  mask_write,
  input  wire logic [NUM_EVENTS-1:0] mask_data,
  // State
  output logic      [NUM_EVENTS-1:0] irq_status,
  output logic      [NUM_EVENTS-1:0] irq_mask,
  output logic                       irq
);

  // Elaboration-time limit on the event count
  if (NUM_EVENTS < 1 || NUM_EVENTS > 16)
  begin : g_events_range
    $error("work_area_irq: NUM_EVENTS out of range");
  end

  wire [NUM_EVENTS-1:0] clear_bits;
  wire [NUM_EVENTS-1:0] next_status;
  wire                  next_irq;

  assign clear_bits  = clear_write ? clear_data : '0;
  // Set wins over a write-one-to-clear landing in the same cycle
  assign next_status = (irq_status & ~clear_bits) | event_set;
  assign next_irq    = |(next_status & (mask_write ? mask_data : irq_mask));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      if (mask_write)
        irq_mask <= mask_data;
      irq        <= next_irq;
    end
  end

endmodule : work_area_irq

// File: rtl/work_area_regs.sv
`timescale 1ns/1ns
`include "work_area_consts.svh"

// Overview of operation
// - Command queue empty status reads 0 whenever any entry is queued.
// - Each processing-unit status bit is the inverse of its irq flag.
// - Work area one low holds start address bits 15:0, read/write.
// - Work area one high holds start address bits 23:16 in bits 7:0.
// - Bits 15:8 of work area one high are unimplemented and read 0.
// - Work area two low holds start address bits 15:0, read/write.
// - Work area two high holds bits 23:16 in 7:0, bits 15:8 read 0.

module work_area_regs
  import work_area_pkg::*;
#(
  parameter int NUM_UNITS  = 4,
  parameter int CNT_WIDTH  = 5
)
(
  // APB slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Command engine status, same clock
  input  wire logic [CNT_WIDTH-1:0] cmd_queue_count,
  input  wire logic [NUM_UNITS-1:0] processing_unit_irq_flag,
  // Work area start addresses to the drawing engine
  output work_addr_t                work_area_one_start,
  output work_addr_t                work_area_two_start,
  // Interrupt
  output logic                      irq
);

  // Elaboration-time limits: unit bits must fit the status word above
  // the empty flag, and the count feeds a plain zero compare
  if (NUM_UNITS < 1 || NUM_UNITS > 8)
  begin : g_units_range
    $error("work_area_regs: NUM_UNITS out of range");
  end
  if (CNT_WIDTH < 1 || CNT_WIDTH > 16)
  begin : g_count_range
    $error("work_area_regs: CNT_WIDTH out of range");
  end
  if (`WA_HIGH_BITS != $bits(addr_high_t))
  begin : g_high_width
    $error("work_area_regs: high register width mismatch");
  end

  function automatic addr_low_t merge_low(input addr_low_t old_value,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    addr_low_t result;
    result = old_value;
    if (strb[0])
      result[7:0] = data[7:0];
    if (strb[1])
      result[15:8] = data[15:8];
    return result;
  endfunction : merge_low

  // Only lane 0 exists in a high register; upper lanes are dropped
  function automatic addr_high_t merge_high(input addr_high_t old_value,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    return strb[0] ? data[7:0] : old_value;
  endfunction : merge_high

  // Exact byte-address match; an address inside a word but off its
  // first byte counts as unmapped
  function automatic logic hit_offset(input logic [11:0] addr,
                                      input logic [11:0] offset);
    return addr == offset;
  endfunction : hit_offset

  addr_low_t  work_area_one_addr_low;
  addr_high_t work_area_one_addr_high;
  addr_low_t  work_area_two_addr_low;
  addr_high_t work_area_two_addr_high;

  logic       queue_empty;
  logic [NUM_UNITS-1:0] unit_busy;

  wire  [1:0] irq_status;
  wire  [1:0] irq_mask;
  wire        irq_next;

  // Decode
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire hit_st   = hit_offset(paddr, `WA_OFF_STATUS);
  wire hit_is   = hit_offset(paddr, `WA_OFF_IRQ_STATUS);
  wire hit_im   = hit_offset(paddr, `WA_OFF_IRQ_MASK);
  wire hit_1l   = hit_offset(paddr, `WA_OFF_ONE_LOW);
  wire hit_1h   = hit_offset(paddr, `WA_OFF_ONE_HIGH);
  wire hit_2l   = hit_offset(paddr, `WA_OFF_TWO_LOW);
  wire hit_2h   = hit_offset(paddr, `WA_OFF_TWO_HIGH);
  // Holes between registers fall through to the error answer
  wire mapped   = hit_st | hit_is | hit_im | hit_1l | hit_1h
                | hit_2l | hit_2h;
  // Status register is read-only; a write to it is an error
  wire bad      = !mapped || (pwrite && hit_st);
  wire take     = psel && !penable;

  // Write strobes; a register changes only at the edge that ends the
  // access cycle, the one at which the master sees pready
  wire wr_done  = wr && pready;
  wire wr_is    = wr_done && hit_is && pstrb[0];
  wire wr_im    = wr_done && hit_im && pstrb[0];
  wire wr_1l    = wr_done && hit_1l;
  wire wr_1h    = wr_done && hit_1h;
  wire wr_2l    = wr_done && hit_2l;
  wire wr_2h    = wr_done && hit_2h;

  // Next register contents; lanes without a strobe keep their byte
  addr_low_t  next_one_low;
  addr_high_t next_one_high;
  addr_low_t  next_two_low;
  addr_high_t next_two_high;
  assign next_one_low  = merge_low(work_area_one_addr_low, pwdata, pstrb);
  assign next_one_high = merge_high(work_area_one_addr_high, pwdata, pstrb);
  assign next_two_low  = merge_low(work_area_two_addr_low, pwdata, pstrb);
  assign next_two_high = merge_high(work_area_two_addr_high, pwdata, pstrb);

  // Start addresses as the drawing engine sees them
  work_addr_t next_one_start;
  work_addr_t next_two_start;
  assign next_one_start = {work_area_one_addr_high,
                           work_area_one_addr_low};
  assign next_two_start = {work_area_two_addr_high,
                           work_area_two_addr_low};

  // Events: queue drains to empty, any unit finishes
  // A fall of a busy bit marks a unit that has finished
  wire next_empty = cmd_queue_count == '0;
  wire [NUM_UNITS-1:0] next_busy = ~processing_unit_irq_flag;
  wire [1:0] event_set;
  assign event_set[`WA_IRQ_EMPTY_BIT] = next_empty && !queue_empty;
  assign event_set[`WA_IRQ_PU_BIT]    = |(unit_busy & ~next_busy);

  // Status word; unused bits read 0
  logic [31:0] status_word;
  always_comb
  begin
    status_word                             = 32'h0;
    status_word[`WA_ST_EMPTY_BIT]           = queue_empty;
    status_word[`WA_ST_PU_LSB +: NUM_UNITS] = unit_busy;
  end

  // Read words, zero above each register's implemented width
  wire [31:0] rd_irq_status = {30'h0, irq_status};
  wire [31:0] rd_irq_mask   = {30'h0, irq_mask};
  wire [31:0] rd_one_low    = {16'h0, work_area_one_addr_low};
  wire [31:0] rd_one_high   = {24'h0, work_area_one_addr_high};
  wire [31:0] rd_two_low    = {16'h0, work_area_two_addr_low};
  wire [31:0] rd_two_high   = {24'h0, work_area_two_addr_high};

  wire [31:0] read_mux;
  assign read_mux =
      hit_st ? status_word
    : hit_is ? rd_irq_status
    : hit_im ? rd_irq_mask
    : hit_1l ? rd_one_low
    : hit_1h ? rd_one_high
    : hit_2l ? rd_two_low
    : hit_2h ? rd_two_high
    : 32'h0;

  // Answer is computed in the setup cycle and registered, so it stands
  // for exactly the one access cycle that follows
  wire        next_ready = take;
  wire        next_err   = take && bad;
  wire [31:0] next_rdata = (take && !pwrite) ? read_mux : 32'h0;

  work_area_irq #(
    .NUM_EVENTS (2)
  ) u_irq (
    .pclk        (pclk),
    .presetn     (presetn),
    .event_set   (event_set),
    .clear_write (wr_is),
    .clear_data  (pwdata[1:0]),
    .mask_write  (wr_im),
    .mask_data   (pwdata[1:0]),
    .irq_status  (irq_status),
    .irq_mask    (irq_mask),
    .irq         (irq_next)
  );

  // The interrupt flop sits in the submodule; no extra stage here
  assign irq = irq_next;

  // Status snapshots; combined with the registered read they stay two
  // cycles behind the engine, which software cannot observe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      queue_empty <= 1'b1;
    end
    else
    begin
      queue_empty <= next_empty;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_busy <= '0;
    end
    else
    begin
      unit_busy <= next_busy;
    end
  end

  // Address registers; odd addresses are stored as written, software
  // keeps bit 0 clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_one_addr_low <= `WA_RST_ADDR_LOW;
    end
    else if (wr_1l)
    begin
      work_area_one_addr_low <= next_one_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_one_addr_high <= `WA_RST_ADDR_HIGH;
    end
    else if (wr_1h)
    begin
      work_area_one_addr_high <= next_one_high;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_two_addr_low <= `WA_RST_ADDR_LOW;
    end
    else if (wr_2l)
    begin
      work_area_two_addr_low <= next_two_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_two_addr_high <= `WA_RST_ADDR_HIGH;
    end
    else if (wr_2h)
    begin
      work_area_two_addr_high <= next_two_high;
    end
  end

  // Start addresses presented to the drawing engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_one_start <= '0;
    end
    else
    begin
      work_area_one_start <= next_one_start;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_area_two_start <= '0;
    end
    else
    begin
      work_area_two_start <= next_two_start;
    end
  end

  // APB answer: pready rises in the first access cycle, so every
  // transfer completes with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= next_ready;
    end
  end

  // pslverr rides with pready; the error answer carries no data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= next_err;
    end
  end

  // Unmapped or refused reads return zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
    end
    else
    begin
      prdata <= next_rdata;
    end
  end

endmodule : work_area_regs

// File: dv/work_area_regs_chk.sv
`timescale 1ns/1ns
module work_area_regs_chk
  import work_area_pkg::*;
#(
  parameter int NUM_UNITS = 4,
  parameter int CNT_WIDTH = 5
)
(
  // Everything is watched, nothing driven
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [CNT_WIDTH-1:0] cmd_queue_count,
  input wire logic [NUM_UNITS-1:0] processing_unit_irq_flag,
  input wire work_addr_t           work_area_one_start,
  input wire work_addr_t           work_area_two_start,
  input wire logic                 irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  wire st = rd && paddr == 12'h000;
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr; pwrite && pready; endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_idle; !(psel && penable) |-> !pready && prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_err; pready && paddr > 12'h01c |-> pslverr && prdata == 0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped accepted");
  property p_stwr; pready && pwrite && paddr == 12'h000 |-> pslverr;
  endproperty
  a_stwr: assert property (p_stwr) else $error("status written");
  property p_hi; rd && paddr[3:0] inside {4'h4, 4'hc} && paddr[4]
    |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  // Two samples agree so the status lag cannot mask a mismatch
  property p_empty; st && $past(cmd_queue_count, 2) != 0
    && $past(cmd_queue_count, 3) != 0 |-> !prdata[0]; endproperty
  a_empty: assert property (p_empty) else $error("empty bad");
  property p_pu; st && $past(processing_unit_irq_flag, 2)
    == $past(processing_unit_irq_flag, 3) |-> prdata[8 +: NUM_UNITS]
    == ~$past(processing_unit_irq_flag, 2); endproperty
  a_pu: assert property (p_pu) else $error("unit bit bad");
  property p_start; $changed(work_area_one_start) |->
    $past(pwrite && pready) || $past(pwrite && pready, 2); endproperty
  a_start: assert property (p_start) else $error("start moved");
  property p_land; pready && pwrite && paddr == 12'h010 && pstrb == 4'hf
    |=> ##1 work_area_one_start[15:0] == $past(pwdata[15:0], 2);
  endproperty
  a_land: assert property (p_land) else $error("low lost");
  property p_land_hi; pready && pwrite && paddr == 12'h014 && pstrb[0]
    |=> ##1 work_area_one_start[23:16] == $past(pwdata[7:0], 2);
  endproperty
  a_land_hi: assert property (p_land_hi) else $error("high lost");
endmodule : work_area_regs_chk
bind work_area_regs work_area_regs_chk #(.NUM_UNITS(NUM_UNITS),
  .CNT_WIDTH(CNT_WIDTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmd_queue_count(cmd_queue_count),
  .processing_unit_irq_flag(processing_unit_irq_flag),
  .work_area_one_start(work_area_one_start),
  .work_area_two_start(work_area_two_start), .irq(irq));

// File: dv/tb.sv
`timescale 1ns/1ns
module tb;
  import work_area_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, d, seed = 32'ha97d0d66, mdl[4];
  logic [3:0]  pstrb = 0, flg = 0, s;
  logic [4:0]  cnt = 0;
  logic        pready, pslverr, irq, e;
  work_addr_t  one_s, two_s;
  int          n_mismatch = 0, num_checks = 0, i;
  logic [11:0] adr[4] = '{12'h010, 12'h014, 12'h018, 12'h01c};
  work_area_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_queue_count(cnt), .processing_unit_irq_flag(flg),
    .work_area_one_start(one_s), .work_area_two_start(two_s), .irq(irq));
  initial forever #25 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] b);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= b;
    @(posedge pclk);
    penable <= 1;
    // No cycle count assumed; the watchdog ends a wait on a stuck slave
    do @(posedge pclk); while (pready !== 1'b1);
    chk("pready", pready, 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    foreach (adr[j])
    begin
      mdl[j] = 0;
      apb(0, adr[j], 0, 0);
      chk("reset", r, 0);
    end
    for (int k = 0; k < 12; k++)
    begin
      i = k % 4;
      d = xs();
      d[0] = (i % 2) ? d[0] : 1'b0;
      // A single-lane write shows untouched bytes keep their value
      s = (k == 4) ? 4'h1 : 4'hf;
      apb(1, adr[i], d, s);
      chk("wr_err", e, 0);
      for (int b = 0; b < 4; b++)
        if (s[b]) mdl[i][b*8 +: 8] = d[b*8 +: 8];
      mdl[i] &= (i % 2) ? 32'h000000ff : 32'h0000ffff;
      apb(0, adr[i], 0, 0);
      chk("reg", r, mdl[i]);
      chk("one", one_s, {mdl[1][7:0], mdl[0][15:0]});
      chk("two", two_s, {mdl[3][7:0], mdl[2][15:0]});
    end
    apb(1, 12'h000, xs(), 4'hf);
    chk("st_wr", e, 1);
    apb(0, 12'h020, 0, 0);
    chk("unmap", {r[30:0], e}, 1);
    cnt <= 5'h3;
    flg <= 4'(xs());
    repeat (4) @(posedge pclk);
    apb(0, 12'h000, 0, 0);
    chk("empty", r[0], 0);
    chk("unit", r[11:8] ^ flg, 4'hf);
    cnt <= 5'h0;
    repeat (4) @(posedge pclk);
    apb(0, 12'h000, 0, 0);
    chk("empty", r[0], 1);
    chk("masked", irq, 0);
    apb(1, 12'h008, 3, 4'hf);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1);
    apb(0, 12'h008, 0, 0);
    chk("mask", r, 3);
    apb(0, 12'h004, 0, 0);
    chk("pend", r, {30'h0, 1'b1, flg != 4'h0});
    apb(1, 12'h004, 3, 4'hf);
    repeat (3) @(posedge pclk);
    chk("clear", irq, 0);
    apb(0, 12'h004, 0, 0);
    chk("cleared", r, 0);
    test_done();
  end
endmodule : tb
